// ==== tb/sbf_spi_master.sv ====
// Link master model driving select, clock and data into the slave port
`timescale 1ns/1ps

module sbf_spi_master (
  output logic      sck,
  output logic      ss_n,
  output logic      sdi,
  input  wire logic sdo,
  input  wire logic sdo_oe
);
  // Clock low and still between frames, select released
  initial begin
    sck  = 1'b0;
    ss_n = 1'b1;
    sdi  = 1'b1;
  end

  // Sends n words MSB first; the answer is taken just before each fall,
  // since the slave only moves its output after a fall it has synced
  task automatic frame(input int n, input logic [31:0] tx, output logic [31:0] rx);
    rx = 32'h0;
    #7;
    ss_n = 1'b0;
    #200;
    for (int i = 0; i < 8 * n; i++) begin
      sdi = tx[31];
      tx  = tx << 1;
      #200 sck = 1'b1;
      #190 rx = {rx[30:0], sdo & sdo_oe}; // Undriven output reads as zero
      #10 sck = 1'b0;
    end
    #200 ss_n = 1'b1;
    sdi = ~sdi; // A released line must not keep its last value
  endtask
endmodule

// ==== tb/sbf_spi_status_props.sv ====
// Port-level checks for the serial buffer-full status block
`timescale 1ns/1ps
`include "sbf_defines.svh"

module sbf_spi_status_props (
  input wire logic                  clk,
  input wire logic                  resetn,
  input wire sbf_pkg::sbf_bus_req_s bus_req,
  input wire logic [`SBF_REG_W-1:0] bus_rdata,
  input wire sbf_pkg::sbf_link_in_s link_in,
  input wire logic                  sdo,
  input wire logic                  sdo_oe,
  input wire logic                  irq
);
  logic       en_r;
  logic       enh_r;
  logic [2:0] msk_r;
  logic [2:0] quiet_r;
  logic       quiet;
  logic       wr_st;
  logic       wr_dat;
  logic       rd_st;
  logic       rd_dat;
  logic       rd_ist;
  logic       rd_bad;

  // Decoded strobes
  assign wr_st  = bus_req.wr && bus_req.addr == `SBF_ADDR_STAT;
  assign wr_dat = bus_req.wr && bus_req.addr == `SBF_ADDR_DATA;
  assign rd_st  = bus_req.rd && bus_req.addr == `SBF_ADDR_STAT;
  assign rd_dat = bus_req.rd && bus_req.addr == `SBF_ADDR_DATA;
  assign rd_ist = bus_req.rd && bus_req.addr == `SBF_ADDR_IRQ_ST;
  assign rd_bad = bus_req.rd && !(bus_req.addr inside {`SBF_ADDR_STAT, `SBF_ADDR_DATA,
                                                       `SBF_ADDR_IRQ_ST, `SBF_ADDR_IRQ_MSK});
  // Link counts as quiet after six idle cycles, so no move can race a check
  assign quiet  = quiet_r == 3'h6;

  // Shadow of enable, mode and mask, as software wrote them
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      en_r  <= 1'b0;
      enh_r <= 1'b0;
      msk_r <= 3'h0;
    end else if (wr_st) begin
      en_r  <= bus_req.wdata[`SBF_ST_EN];
      enh_r <= bus_req.wdata[`SBF_ST_ENH];
    end else if (bus_req.wr && bus_req.addr == `SBF_ADDR_IRQ_MSK) begin
      msk_r <= bus_req.wdata[2:0];
    end
  end

  // Idle-select counter, saturating
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) quiet_r <= 3'h0;
    else if (!link_in.ss_n) quiet_r <= 3'h0;
    else if (!quiet) quiet_r <= quiet_r + 3'h1;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  AST_RDATA_IDLE: assert property (!bus_req.rd |=> bus_rdata == `SBF_REG_RST)
    else $error("read data not zero outside a read answer");
  AST_UNMAPPED_ZERO: assert property (rd_bad |=> bus_rdata == `SBF_REG_RST)
    else $error("unmapped read returned nonzero");
  AST_STAT_RSVD: assert property (rd_st |=> bus_rdata[14:3] == 12'h000)
    else $error("unused status bits read nonzero");
  AST_TBF_SET_STD: assert property (
    quiet && en_r && !enh_r && wr_dat ##1 rd_st |=> bus_rdata[`SBF_ST_TBF])
    else $error("transmit full not set by data write");
  AST_RBF_CLR_STD: assert property (
    quiet && en_r && !enh_r && rd_dat ##1 rd_st |=> !bus_rdata[`SBF_ST_RBF])
    else $error("receive full not cleared by data read");
  AST_RBF_CLR_ENH: assert property (
    quiet && en_r && enh_r && rd_dat ##1 rd_st |=> !bus_rdata[`SBF_ST_RBF])
    else $error("receive full kept after an entry was freed");
  AST_FLAGS_RO: assert property (
    wr_st && !bus_req.wdata[`SBF_ST_EN] ##1 rd_st |=> bus_rdata[1:0] == 2'h0)
    else $error("flag bits took a software write");
  AST_IRQ_LEVEL: assert property (rd_ist |=> irq == |(bus_rdata[2:0] & $past(msk_r)))
    else $error("interrupt level disagrees with status and mask");
  AST_OE_IDLE: assert property ((link_in.ss_n || !en_r) [*6] |-> !sdo_oe)
    else $error("data out driven while not selected");

  cover property (quiet && wr_dat ##1 rd_st);
  cover property (quiet && enh_r && rd_dat ##1 rd_st);
  cover property ($rose(irq));
  cover property ($fell(sdo_oe));
  cover property (sdo_oe && sdo);
endmodule

bind sbf_spi_status sbf_spi_status_props i_sbf_spi_status_props (
  .clk(clk), .resetn(resetn), .bus_req(bus_req), .bus_rdata(bus_rdata),
  .link_in(link_in), .sdo(sdo), .sdo_oe(sdo_oe), .irq(irq));

// ==== tb/test_spi_buffer_full_status.sv ====
// Self-checking bench for the serial buffer-full status block
`timescale 1ns/1ps
`include "sbf_defines.svh"

module test_spi_buffer_full_status;
  logic                  clk;
  logic                  resetn;
  sbf_pkg::sbf_bus_req_s bus_req;
  logic [15:0]           bus_rdata;
  sbf_pkg::sbf_link_in_s link_in;
  logic                  sck;
  logic                  ss_n;
  logic                  sdi;
  logic                  sdo;
  logic                  sdo_oe;
  logic                  irq;
  int                    bad_count;
  int                    samples_checked;
  logic [15:0]           v;
  logic [15:0]           v2;
  logic [31:0]           rx;

  assign link_in = {sck, ss_n, sdi};

  sbf_spi_status i_sbf_spi_status (.clk(clk), .resetn(resetn), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .link_in(link_in), .sdo(sdo), .sdo_oe(sdo_oe), .irq(irq));
  sbf_spi_master i_sbf_spi_master (.sck(sck), .ss_n(ss_n), .sdi(sdi), .sdo(sdo),
    .sdo_oe(sdo_oe));

  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic end_of_test;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check_reg(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask

  // Reads return data in the cycle after the strobe; one idle cycle follows
  task automatic rd(input logic [3:0] a, output logic [15:0] q);
    bus_req.addr <= a;
    bus_req.rd   <= 1'b1;
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1 q = bus_rdata;
    @(posedge clk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    bus_req.addr  <= a;
    bus_req.wdata <= d;
    bus_req.wr    <= 1'b1;
    @(posedge clk);
    bus_req.wr <= 1'b0;
    @(posedge clk);
  endtask

  // Write followed by a read with no gap
  task automatic wr_rd(input logic [3:0] a, input logic [15:0] d, input logic [3:0] ra,
                       output logic [15:0] q);
    bus_req.addr  <= a;
    bus_req.wdata <= d;
    bus_req.wr    <= 1'b1;
    @(posedge clk);
    bus_req.wr <= 1'b0;
    rd(ra, q);
  endtask

  // Two reads back to back, strobe held high across both
  task automatic rd2(input logic [3:0] a, input logic [3:0] b, output logic [15:0] q,
                     output logic [15:0] r);
    bus_req.addr <= a;
    bus_req.rd   <= 1'b1;
    @(posedge clk);
    bus_req.addr <= b;
    #1 q = bus_rdata;
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1 r = bus_rdata;
    @(posedge clk);
  endtask

  // Interrupt output lags its cause by one cycle
  task automatic irq_is(input logic exp);
    #1 check_bit(irq, exp);
    @(posedge clk);
  endtask

  // Hang guard
  initial begin
    repeat (4000) @(posedge clk);
    bad_count++;
    $display("wrong value at %0t: run did not finish", $time);
    end_of_test;
  end

  initial begin
    bus_req         = '0;
    resetn          = 1'b0;
    bad_count       = 0;
    samples_checked = 0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    // All registers, data window and an unmapped place read zero
    for (int a = 0; a < 10; a += 2) begin
      rd(4'(a), v);
      check_reg(v, 16'h0000);
    end
    // Standard mode: flag bits ignore software, data write fills the buffer
    wr(4'hA, 16'hFFFF);
    wr_rd(`SBF_ADDR_STAT, 16'h8003, `SBF_ADDR_STAT, v);
    check_reg(v, 16'h8000);
    wr_rd(`SBF_ADDR_DATA, 16'h005A, `SBF_ADDR_STAT, v);
    check_reg(v, 16'h8002);
    wr(`SBF_ADDR_DATA, 16'h00A5); // Dropped: buffer already full
    // Two-word frame: second word finds the receive side full
    i_sbf_spi_master.frame(2, 32'hC33C0000, rx);
    repeat (8) @(posedge clk);
    check_reg(rx[15:0], 16'h5A00);
    rd(`SBF_ADDR_STAT, v);
    check_reg(v, 16'h8001);
    rd(`SBF_ADDR_IRQ_ST, v);
    check_reg(v, 16'h0007);
    rd2(`SBF_ADDR_DATA, `SBF_ADDR_STAT, v, v2);
    check_reg(v, 16'h00C3);
    check_reg(v2, 16'h8000);
    // Interrupt masked, unmasked, then cleared
    irq_is(1'b0);
    wr(`SBF_ADDR_IRQ_MSK, 16'h0004);
    irq_is(1'b1);
    wr(`SBF_ADDR_IRQ_ST, 16'h0004);
    irq_is(1'b0);
    rd(`SBF_ADDR_IRQ_ST, v);
    check_reg(v, 16'h0003);
    // Enhanced mode: full only when the last entry is taken
    wr(`SBF_ADDR_STAT, 16'h8004);
    for (int i = 0; i < 4; i++) begin
      wr_rd(`SBF_ADDR_DATA, 16'(17 * (i + 1)), `SBF_ADDR_STAT, v);
      check_reg(v, (i == 3) ? 16'h8006 : 16'h8004);
    end
    i_sbf_spi_master.frame(4, 32'hA1B2C3D4, rx);
    repeat (8) @(posedge clk);
    check_reg(rx[31:16], 16'h1122);
    check_reg(rx[15:0], 16'h3344);
    rd(`SBF_ADDR_STAT, v);
    check_reg(v, 16'h8005);
    for (int i = 0; i < 4; i++) begin
      rd2(`SBF_ADDR_DATA, `SBF_ADDR_STAT, v, v2);
      check_reg(v, {8'h00, 8'(32'hA1B2C3D4 >> (24 - 8 * i))});
      check_reg(v2, 16'h8004);
    end
    // Disabling with ones in the flag bits leaves both flags clear
    wr_rd(`SBF_ADDR_STAT, 16'h0003, `SBF_ADDR_STAT, v);
    check_reg(v, 16'h0000);
    end_of_test;
  end
endmodule

// ==== verilog/sbf_buf_mem.sv ====
// Small word store for the transmit and receive buffers
`timescale 1ns/1ps
`include "sbf_defines.svh"

module sbf_buf_mem (
  input  wire logic                   clk,
  input  wire logic                   resetn,
  input  wire logic                   we,
  input  wire logic [`SBF_PTR_W-1:0]  waddr,
  input  wire logic [`SBF_WORD_W-1:0] wdata,
  input  wire logic [`SBF_PTR_W-1:0]  raddr,
  output logic      [`SBF_WORD_W-1:0] rdata
);

  logic [`SBF_WORD_W-1:0] mem_r [`SBF_DEPTH_ENH];

  // Storage array, no reset needed
  always_ff @(posedge clk) begin
    if (we) begin
      mem_r[waddr] <= wdata;
    end
  end

  // Registered read; forward a same-cycle write so data is never stale
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= `SBF_WORD_RST;
    end else if (we && (waddr == raddr)) begin
      rdata <= wdata;
    end else begin
      rdata <= mem_r[raddr];
    end
  end

endmodule

// ==== verilog/sbf_defines.svh ====
// Constants for the serial buffer-full status block
`ifndef SBF_DEFINES_SVH
`define SBF_DEFINES_SVH

// Register byte addresses
`define SBF_ADDR_W        4
`define SBF_ADDR_STAT     4'h0
`define SBF_ADDR_DATA     4'h2
`define SBF_ADDR_IRQ_ST   4'h4
`define SBF_ADDR_IRQ_MSK  4'h6

// Status and control field positions
`define SBF_ST_RBF        0
`define SBF_ST_TBF        1
`define SBF_ST_ENH        2
`define SBF_ST_EN         15

// Interrupt event positions
`define SBF_EV_RX_WORD    0
`define SBF_EV_TX_LOAD    1
`define SBF_EV_RX_OVF     2
`define SBF_EV_W          3

// Widths, depths and reset values
`define SBF_REG_W         16
`define SBF_WORD_W        8
`define SBF_PTR_W         2
`define SBF_CNT_W         3
`define SBF_DEPTH_STD     3'h1
`define SBF_DEPTH_ENH     3'h4
`define SBF_PTR_ONE       2'h1
`define SBF_CNT_ONE       3'h1
`define SBF_BIT_LAST      3'h7
`define SBF_BIT_ONE       3'h1
`define SBF_REG_RST       16'h0000
`define SBF_WORD_RST      8'h00
`define SBF_EV_RST        3'h0
`define SBF_SYNC_RST      3'h2
`define SBF_PTR_ZERO      2'h0
`define SBF_CNT_ZERO      3'h0
`define SBF_PAD_WORD      8'h00
`define SBF_PAD_EV        13'h0000

`endif

// ==== verilog/sbf_pkg.sv ====
// Types shared by the serial buffer-full status block
`include "sbf_defines.svh"

package sbf_pkg;

  // Register port request from the core
  typedef struct packed {
    logic [`SBF_ADDR_W-1:0] addr;
    logic [`SBF_REG_W-1:0]  wdata;
    logic                   wr;
    logic                   rd;
  } sbf_bus_req_s;

  // Serial link inputs, sampled by the block clock
  typedef struct packed {
    logic sck;
    logic ss_n;
    logic sdi;
  } sbf_link_in_s;

  // Link sequencer, Gray coded from idle through load and shift to done
  typedef enum logic [1:0] {
    SBF_LK_IDLE  = 2'h0,
    SBF_LK_LOAD  = 2'h1,
    SBF_LK_SHIFT = 2'h3,
    SBF_LK_DONE  = 2'h2
  } sbf_link_e;

endpackage

// ==== verilog/sbf_spi_status.sv ====
// Serial peripheral slave with transmit/receive buffer-full status flags
//
// What this block does
// - Transmit-full flag, status bit 1: set while holding buffer loaded, unsent.
// - Standard mode: core write to the data window sets transmit-full.
// - Standard mode: move from holding buffer to shifter clears transmit-full.
// - Enhanced mode: transmit-full sets only when a write takes the last entry.
// - Enhanced mode: transmit-full clears once any entry is free for writing.
// - Receive-full flag, status bit 0: set when received word waits, unread.
// - Standard mode: move from shifter into holding buffer sets receive-full.
// - Standard mode: core read of the data window clears receive-full.
// - Enhanced mode: receive-full sets when a move fills the last free entry.
// - Enhanced mode: receive-full clears once any entry can take a word.
//
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "sbf_defines.svh"

module sbf_spi_status (
  input  wire logic                  clk,
  input  wire logic                  resetn,
  input  wire sbf_pkg::sbf_bus_req_s bus_req,
  output logic [`SBF_REG_W-1:0]      bus_rdata,
  input  wire sbf_pkg::sbf_link_in_s link_in,
  output logic                       sdo,
  output logic                       sdo_oe,
  output logic                       irq
);

  // Buffer capacity for the selected mode
  function automatic logic [`SBF_CNT_W-1:0] buf_depth(input logic enh);
    buf_depth = enh ? `SBF_DEPTH_ENH : `SBF_DEPTH_STD;
  endfunction

  // A buffer is full when its count reaches the mode's capacity
  function automatic logic buf_full(input logic [`SBF_CNT_W-1:0] cnt,
                                    input logic                  enh);
    buf_full = (cnt == buf_depth(enh));
  endfunction

  // Pointer advance, wraps over the four entries
  function automatic logic [`SBF_PTR_W-1:0] ptr_next(
      input logic [`SBF_PTR_W-1:0] ptr, input logic step);
    ptr_next = step ? ptr + `SBF_PTR_ONE : ptr;
  endfunction

  // Count update for one push and one pop in the same cycle
  function automatic logic [`SBF_CNT_W-1:0] cnt_next(
      input logic [`SBF_CNT_W-1:0] cnt, input logic push, input logic pop);
    logic [`SBF_CNT_W-1:0] c;
    c = cnt;
    if (push && !pop) begin
      c = cnt + `SBF_CNT_ONE;
    end else if (pop && !push) begin
      c = cnt - `SBF_CNT_ONE;
    end
    cnt_next = c;
  endfunction

  // Synchronised link pins
  logic [2:0]                sync_q;
  logic                      sck_s;
  logic                      ss_n_s;
  logic                      sdi_s;
  logic                      sck_d_r;
  logic                      sck_rise;
  logic                      sck_fall;

  // Control and status
  logic                      ctl_en_r;
  logic                      ctl_enh_r;
  logic                      tbf_r;
  logic                      rbf_r;
  logic [`SBF_EV_W-1:0]      ev_stat_r;
  logic [`SBF_EV_W-1:0]      ev_mask_r;
  logic [`SBF_EV_W-1:0]      ev_set;

  // Link side
  sbf_pkg::sbf_link_e        lk_state_r;
  logic [2:0]                bit_cnt_r;
  logic [`SBF_WORD_W-1:0]    sh_tx_r;
  logic [`SBF_WORD_W-1:0]    sh_rx_r;

  // Buffers
  logic [`SBF_PTR_W-1:0]     tx_wp_r;
  logic [`SBF_PTR_W-1:0]     tx_rp_r;
  logic [`SBF_CNT_W-1:0]     tx_cnt_r;
  logic [`SBF_PTR_W-1:0]     rx_wp_r;
  logic [`SBF_PTR_W-1:0]     rx_rp_r;
  logic [`SBF_CNT_W-1:0]     rx_cnt_r;
  logic [`SBF_WORD_W-1:0]    tx_q;
  logic [`SBF_WORD_W-1:0]    rx_q;
  logic [`SBF_PTR_W-1:0]     tx_rp_nxt;
  logic [`SBF_PTR_W-1:0]     rx_rp_nxt;
  logic [`SBF_CNT_W-1:0]     tx_cnt_nxt;
  logic [`SBF_CNT_W-1:0]     rx_cnt_nxt;

  // Decoded events
  logic                      wr_stat;
  logic                      wr_data;
  logic                      rd_data;
  logic                      wr_ev_st;
  logic                      wr_ev_msk;
  logic                      flush;
  logic                      tx_push;
  logic                      tx_pop;
  logic                      rx_push;
  logic                      rx_pop;
  logic                      rx_ovf;
  logic                      byte_done;
  logic [`SBF_REG_W-1:0]     stat_word;

  sbf_sync u_sync (
    .clk    (clk),
    .resetn (resetn),
    .d      ({link_in.sck, link_in.ss_n, link_in.sdi}),
    .q      (sync_q)
  );

  assign sck_s  = sync_q[2];
  assign ss_n_s = sync_q[1];
  assign sdi_s  = sync_q[0];

  // Edge finder on the sampled link clock
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sck_d_r <= 1'b0;
    end else begin
      sck_d_r <= sck_s;
    end
  end

  assign sck_rise = sck_s && !sck_d_r;
  assign sck_fall = !sck_s && sck_d_r;

  // Register port decode
  assign wr_stat   = bus_req.wr && (bus_req.addr == `SBF_ADDR_STAT);
  assign wr_data   = bus_req.wr && (bus_req.addr == `SBF_ADDR_DATA);
  assign rd_data   = bus_req.rd && (bus_req.addr == `SBF_ADDR_DATA);
  assign wr_ev_st  = bus_req.wr && (bus_req.addr == `SBF_ADDR_IRQ_ST);
  assign wr_ev_msk = bus_req.wr && (bus_req.addr == `SBF_ADDR_IRQ_MSK);

  // Changing mode or disabling empties both buffers, so counts never
  // exceed the capacity of the newly selected mode
  assign flush = wr_stat &&
                 ((bus_req.wdata[`SBF_ST_ENH] != ctl_enh_r) ||
                  !bus_req.wdata[`SBF_ST_EN]);

  // A write to a full transmit buffer is dropped rather than overwriting
  assign tx_push   = wr_data && ctl_en_r && !buf_full(tx_cnt_r, ctl_enh_r);
  assign tx_pop    = (lk_state_r == sbf_pkg::SBF_LK_LOAD) && (tx_cnt_r != `SBF_CNT_ZERO);
  assign byte_done = (lk_state_r == sbf_pkg::SBF_LK_DONE);
  assign rx_push   = byte_done && !buf_full(rx_cnt_r, ctl_enh_r);
  assign rx_ovf    = byte_done && buf_full(rx_cnt_r, ctl_enh_r);
  assign rx_pop    = rd_data && (rx_cnt_r != `SBF_CNT_ZERO);

  assign tx_cnt_nxt = cnt_next(tx_cnt_r, tx_push, tx_pop);
  assign rx_cnt_nxt = cnt_next(rx_cnt_r, rx_push, rx_pop);
  assign tx_rp_nxt  = ptr_next(tx_rp_r, tx_pop);
  assign rx_rp_nxt  = ptr_next(rx_rp_r, rx_pop);

  // Read address leads by one so the registered read data is current
  sbf_buf_mem u_tx_mem (
    .clk    (clk),
    .resetn (resetn),
    .we     (tx_push),
    .waddr  (tx_wp_r),
    .wdata  (bus_req.wdata[`SBF_WORD_W-1:0]),
    .raddr  (tx_rp_nxt),
    .rdata  (tx_q)
  );

  sbf_buf_mem u_rx_mem (
    .clk    (clk),
    .resetn (resetn),
    .we     (rx_push),
    .waddr  (rx_wp_r),
    .wdata  (sh_rx_r),
    .raddr  (rx_rp_nxt),
    .rdata  (rx_q)
  );

  // Software control bits; flag positions in the same word stay untouched
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctl_en_r  <= 1'b0;
      ctl_enh_r <= 1'b0;
    end else if (wr_stat) begin
      ctl_en_r  <= bus_req.wdata[`SBF_ST_EN];
      ctl_enh_r <= bus_req.wdata[`SBF_ST_ENH];
    end
  end

  // Transmit buffer pointers and fill count
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_wp_r  <= `SBF_PTR_ZERO;
      tx_rp_r  <= `SBF_PTR_ZERO;
      tx_cnt_r <= `SBF_CNT_ZERO;
    end else if (flush) begin
      tx_wp_r  <= `SBF_PTR_ZERO;
      tx_rp_r  <= `SBF_PTR_ZERO;
      tx_cnt_r <= `SBF_CNT_ZERO;
    end else begin
      tx_wp_r  <= ptr_next(tx_wp_r, tx_push);
      tx_rp_r  <= tx_rp_nxt;
      tx_cnt_r <= tx_cnt_nxt;
    end
  end

  // Receive buffer pointers and fill count
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_wp_r  <= `SBF_PTR_ZERO;
      rx_rp_r  <= `SBF_PTR_ZERO;
      rx_cnt_r <= `SBF_CNT_ZERO;
    end else if (flush) begin
      rx_wp_r  <= `SBF_PTR_ZERO;
      rx_rp_r  <= `SBF_PTR_ZERO;
      rx_cnt_r <= `SBF_CNT_ZERO;
    end else begin
      rx_wp_r  <= ptr_next(rx_wp_r, rx_push);
      rx_rp_r  <= rx_rp_nxt;
      rx_cnt_r <= rx_cnt_nxt;
    end
  end

  // Transmit-full follows the count: in standard mode capacity is one,
  // so a write sets it and the move to the shifter clears it; in enhanced
  // mode only the write taking the last entry sets it and any pop clears it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tbf_r <= 1'b0;
    end else if (flush) begin
      tbf_r <= 1'b0;
    end else begin
      tbf_r <= buf_full(tx_cnt_nxt, ctl_enh_r);
    end
  end

  // Receive-full: set when a move fills the last entry, cleared by a core
  // read that frees one; with one entry this is the standard behaviour
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rbf_r <= 1'b0;
    end else if (flush) begin
      rbf_r <= 1'b0;
    end else begin
      rbf_r <= buf_full(rx_cnt_nxt, ctl_enh_r);
    end
  end

  // Link sequencer: load shifter, shift eight bits, hand word over
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lk_state_r <= sbf_pkg::SBF_LK_IDLE;
    end else if (ss_n_s || !ctl_en_r) begin
      lk_state_r <= sbf_pkg::SBF_LK_IDLE;
    end else begin
      case (lk_state_r)
        sbf_pkg::SBF_LK_IDLE: begin
          lk_state_r <= sbf_pkg::SBF_LK_LOAD;
        end
        sbf_pkg::SBF_LK_LOAD: begin
          lk_state_r <= sbf_pkg::SBF_LK_SHIFT;
        end
        sbf_pkg::SBF_LK_SHIFT: begin
          if (sck_rise && (bit_cnt_r == `SBF_BIT_LAST)) begin
            lk_state_r <= sbf_pkg::SBF_LK_DONE;
          end
        end
        sbf_pkg::SBF_LK_DONE: begin
          lk_state_r <= sbf_pkg::SBF_LK_LOAD;
        end
        default: begin
          lk_state_r <= sbf_pkg::SBF_LK_IDLE;
        end
      endcase
    end
  end

  // Bit counter, restarted for every word
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bit_cnt_r <= `SBF_CNT_ZERO;
    end else if (lk_state_r != sbf_pkg::SBF_LK_SHIFT) begin
      bit_cnt_r <= `SBF_CNT_ZERO;
    end else if (sck_rise) begin
      bit_cnt_r <= bit_cnt_r + `SBF_BIT_ONE;
    end
  end

  // Receive shifter samples on rising link clock edges
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sh_rx_r <= `SBF_WORD_RST;
    end else if ((lk_state_r == sbf_pkg::SBF_LK_SHIFT) && sck_rise) begin
      sh_rx_r <= {sh_rx_r[`SBF_WORD_W-2:0], sdi_s};
    end
  end

  // Transmit shifter: loaded from the holding buffer, or zeros when it is
  // empty; a falling edge before the first rise of a word is ignored so
  // the leading bit is not lost
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sh_tx_r <= `SBF_WORD_RST;
    end else if (lk_state_r == sbf_pkg::SBF_LK_LOAD) begin
      sh_tx_r <= tx_pop ? tx_q : `SBF_WORD_RST;
    end else if ((lk_state_r == sbf_pkg::SBF_LK_SHIFT) && sck_fall &&
                 (bit_cnt_r != `SBF_CNT_ZERO)) begin
      sh_tx_r <= {sh_tx_r[`SBF_WORD_W-2:0], 1'b0};
    end
  end

  // Serial output and its enable, driven only while selected
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sdo    <= 1'b0;
      sdo_oe <= 1'b0;
    end else begin
      sdo    <= sh_tx_r[`SBF_WORD_W-1];
      sdo_oe <= !ss_n_s && ctl_en_r;
    end
  end

  // Interrupt events
  always_comb begin
    ev_set                  = `SBF_EV_RST;
    ev_set[`SBF_EV_RX_WORD] = rx_push;
    ev_set[`SBF_EV_TX_LOAD] = tx_pop;
    ev_set[`SBF_EV_RX_OVF]  = rx_ovf;
  end

  // Sticky event bits, write one to clear; a new event beats the clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ev_stat_r <= `SBF_EV_RST;
    end else if (wr_ev_st) begin
      ev_stat_r <= (ev_stat_r & ~bus_req.wdata[`SBF_EV_W-1:0]) | ev_set;
    end else begin
      ev_stat_r <= ev_stat_r | ev_set;
    end
  end

  // Event mask
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ev_mask_r <= `SBF_EV_RST;
    end else if (wr_ev_msk) begin
      ev_mask_r <= bus_req.wdata[`SBF_EV_W-1:0];
    end
  end

  // Level interrupt, one cycle behind the status bits
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(ev_stat_r & ev_mask_r);
    end
  end

  // Status word; flag bits come only from hardware
  always_comb begin
    stat_word               = `SBF_REG_RST;
    stat_word[`SBF_ST_RBF]  = rbf_r;
    stat_word[`SBF_ST_TBF]  = tbf_r;
    stat_word[`SBF_ST_ENH]  = ctl_enh_r;
    stat_word[`SBF_ST_EN]   = ctl_en_r;
  end

  // Read data stands in the cycle after the read strobe only
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bus_rdata <= `SBF_REG_RST;
    end else if (bus_req.rd) begin
      case (bus_req.addr)
        `SBF_ADDR_STAT: begin
          bus_rdata <= stat_word;
        end
        `SBF_ADDR_DATA: begin
          bus_rdata <= {`SBF_PAD_WORD, rx_q};
        end
        `SBF_ADDR_IRQ_ST: begin
          bus_rdata <= {`SBF_PAD_EV, ev_stat_r};
        end
        `SBF_ADDR_IRQ_MSK: begin
          bus_rdata <= {`SBF_PAD_EV, ev_mask_r};
        end
        default: begin
          bus_rdata <= `SBF_REG_RST;
        end
      endcase
    end else begin
      bus_rdata <= `SBF_REG_RST;
    end
  end

endmodule

// ==== verilog/sbf_sync.sv ====
// Two-flop synchroniser for the serial link pins
`timescale 1ns/1ps
`include "sbf_defines.svh"

module sbf_sync (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic [2:0] d,
  output logic      [2:0] q
);

  logic [2:0] meta_r;

  // First stage feeds only the second; select idles high
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_r <= `SBF_SYNC_RST;
      q      <= `SBF_SYNC_RST;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule
